// *** src/pdpo_pkg.sv ***
// Constants for the polar discriminator and parallel output block
package pdpo_pkg;
    // Control word numbers on the load port
    localparam logic [4:0] CW_DISC   = 5'h11;
    localparam logic [4:0] CW_OUTFMT = 5'h14;
    localparam logic [4:0] CW_ROUTE  = 5'h1b;
    localparam logic [4:0] CW_STATUS = 5'h1f;
    localparam logic [31:0] CW_RESET = 32'h0000_0000;
    // Discriminator word fields
    localparam int DLY_LSB  = 0;
    localparam int TAPS_LSB = 3;
    localparam int ASYM_BIT = 9;
    localparam int ODD_BIT  = 10;
    localparam int DEC_LSB  = 11;
    localparam int EN_BIT   = 14;
    localparam int MUL_LSB  = 15;
    // Output format word fields
    localparam int BSEL_LSB = 20;
    localparam int ASEL_LSB = 22;
    localparam int MODE_BIT = 25;
    // Routing word fields
    localparam int DIRECT_BIT = 13;
    localparam int QZERO_BIT  = 14;
    localparam int FSEL_LSB   = 18;
    // Widths
    localparam int PH_W   = 18;
    localparam int FIR_W  = 26;
    localparam int OUT_W  = 16;
    localparam int COEF_W = 16;
    localparam int NTAP   = 63;
    localparam int NCOEF  = 32;
    localparam int NHIST  = 8;
    // Gate delay after AGC ready, in clocks
    localparam int AGC_DLY = 6;
    // Output source codes
    localparam logic [1:0] SRC_0 = 2'h0;
    localparam logic [1:0] SRC_1 = 2'h1;
    localparam logic [1:0] SRC_2 = 2'h2;
    // FIR input select codes
    localparam logic [1:0] FSEL_PHASE = 2'h0;
    localparam logic [1:0] FSEL_MAG   = 2'h1;
    // FIR sequencer states
    typedef enum logic [0:0] {
        PDPO_IDLE = 1'b0,
        PDPO_MAC  = 1'b1
    } pdpo_state_t;
endpackage

// *** src/pdpo_top.sv ***
// Converter routing, frequency discriminator and parallel output stage
`timescale 1ns/1ps
module pdpo_top #(
    parameter int RS_DLY = 4
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    // Control word load and readback
    input  wire logic                 cw_wr_in,
    input  wire logic [4:0]           cw_addr_in,
    input  wire logic [31:0]          cw_data_in,
    input  wire logic [4:0]           cw_rd_addr_in,
    output logic      [31:0]          cw_rd_data_out,
    // Discriminator FIR coefficient load
    input  wire logic                 coef_wr_in,
    input  wire logic [4:0]           coef_addr_in,
    input  wire logic [15:0]          coef_data_in,
    // Upstream sample sources
    input  wire logic [25:0]          fir_i_in,
    input  wire logic [25:0]          fir_q_in,
    input  wire logic                 agc_rdy_in,
    input  wire logic [17:0]          rs_i_in,
    input  wire logic [17:0]          rs_q_in,
    input  wire logic                 rs_rdy_in,
    input  wire logic                 rs_bypass_in,
    // Coordinate converter side
    output logic      [25:0]          conv_i_out,
    output logic      [25:0]          conv_q_out,
    output logic                      conv_strobe_out,
    input  wire logic [17:0]          conv_mag_in,
    input  wire logic [17:0]          conv_phase_in,
    input  wire logic                 conv_rdy_in,
    // Parallel output port
    output logic      [15:0]          parallel_out_a_out,
    output logic      [15:0]          parallel_out_b_out,
    output logic                      output_data_strobe_n_out,
    output logic                      out_valid_out,
    input  wire logic                 out_ready_in,
    output logic                      buf_ready_out
);
    localparam int GATE_AGC = pdpo_pkg::AGC_DLY;
    localparam int GATE_RS  = pdpo_pkg::AGC_DLY + RS_DLY;
    // Edges from the end of the eight-cycle hold to the sampled gate strobe
    localparam int RS_TAIL  = GATE_RS - 8;
    localparam int ACC_W    = 42;

    logic [31:0] disc_cfg_reg, outfmt_cfg_reg, route_cfg_reg;
    logic [GATE_RS-2:0] gate_sh_reg;
    logic        strobe_tap;
    logic [15:0] sym_i_reg, sym_q_reg, mag_reg, phs_reg, freq_reg;

    // Control words; the status word shows live block state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            disc_cfg_reg   <= pdpo_pkg::CW_RESET;
            outfmt_cfg_reg <= pdpo_pkg::CW_RESET;
            route_cfg_reg  <= pdpo_pkg::CW_RESET;
        end else if (cw_wr_in) begin
            if (cw_addr_in == pdpo_pkg::CW_DISC)   disc_cfg_reg   <= cw_data_in;
            if (cw_addr_in == pdpo_pkg::CW_OUTFMT) outfmt_cfg_reg <= cw_data_in;
            if (cw_addr_in == pdpo_pkg::CW_ROUTE)  route_cfg_reg  <= cw_data_in;
        end
    end

    // Field decode
    wire [1:0] mul_sel  = disc_cfg_reg[pdpo_pkg::MUL_LSB +: 2];
    wire       disc_en  = disc_cfg_reg[pdpo_pkg::EN_BIT];
    wire [2:0] dec_fld  = disc_cfg_reg[pdpo_pkg::DEC_LSB +: 3];
    wire       odd_sym  = disc_cfg_reg[pdpo_pkg::ODD_BIT];
    wire       asym     = disc_cfg_reg[pdpo_pkg::ASYM_BIT];
    wire [5:0] taps_fld = disc_cfg_reg[pdpo_pkg::TAPS_LSB +: 6];
    wire [2:0] dly_fld  = disc_cfg_reg[pdpo_pkg::DLY_LSB +: 3];
    wire [1:0] asel     = outfmt_cfg_reg[pdpo_pkg::ASEL_LSB +: 2];
    wire [1:0] bsel     = outfmt_cfg_reg[pdpo_pkg::BSEL_LSB +: 2];
    wire       buf_mode = outfmt_cfg_reg[pdpo_pkg::MODE_BIT];
    wire       direct   = route_cfg_reg[pdpo_pkg::DIRECT_BIT];
    wire       qzero    = route_cfg_reg[pdpo_pkg::QZERO_BIT];
    wire [1:0] fsel     = route_cfg_reg[pdpo_pkg::FSEL_LSB +: 2];

    // Converter gate: one strobe shift line, tapped per resampler use
    assign strobe_tap = rs_bypass_in ? gate_sh_reg[GATE_AGC-2]
                                     : gate_sh_reg[GATE_RS-2];
    wire [25:0] conv_i_next = direct ? fir_i_in : {rs_i_in, 8'h00};
    wire [25:0] conv_q_sel  = direct ? fir_q_in : {rs_q_in, 8'h00};
    wire [25:0] conv_q_next = qzero ? 26'h000_0000 : conv_q_sel;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_sh_reg     <= '0;
            conv_strobe_out <= 1'b0;
            conv_i_out      <= '0;
            conv_q_out      <= '0;
        end else begin
            gate_sh_reg     <= {gate_sh_reg[GATE_RS-3:0],
                                rs_bypass_in ? agc_rdy_in : rs_rdy_in};
            conv_strobe_out <= strobe_tap;
            if (strobe_tap) begin
                conv_i_out <= conv_i_next;
                conv_q_out <= conv_q_next;
            end
        end
    end

    // Discriminator: multiply, D-sample history and modulo subtract
    logic [17:0] hist_reg [pdpo_pkg::NHIST];
    wire  [17:0] ph_mul  = 18'(conv_phase_in << mul_sel);
    wire  [2:0]  hidx    = dly_fld - 3'h1;
    wire  [17:0] diff_w  = ph_mul - hist_reg[hidx];
    wire         ph_stb  = conv_rdy_in && disc_en && fsel == pdpo_pkg::FSEL_PHASE;
    logic [17:0] fir_x_reg;
    logic        fir_stb_reg;

    // Select FIR input and its strobe
    wire fx_from_rs = fsel[1];
    wire fx_stb     = disc_en && (fx_from_rs ? rs_rdy_in : conv_rdy_in);
    wire [17:0] fx_in = fx_from_rs ? rs_i_in :
                        (fsel == pdpo_pkg::FSEL_MAG) ? conv_mag_in : diff_w;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int h = 0; h < pdpo_pkg::NHIST; h++) hist_reg[h] <= '0;
            fir_x_reg   <= '0;
            fir_stb_reg <= 1'b0;
        end else begin
            fir_stb_reg <= fx_stb;
            if (fx_stb) fir_x_reg <= fx_in;
            if (ph_stb) begin
                hist_reg[0] <= ph_mul;
                for (int h = 1; h < pdpo_pkg::NHIST; h++) hist_reg[h] <= hist_reg[h-1];
            end
        end
    end

    // Coefficient store, written from the load port
    logic signed [15:0] coef_mem [pdpo_pkg::NCOEF];
    always_ff @(posedge clk_in) begin
        if (coef_wr_in) coef_mem[coef_addr_in] <= coef_data_in;
    end

    // Sample line for the discriminator FIR, newest at index 0
    logic [17:0] xline_reg [pdpo_pkg::NTAP];
    logic [2:0]  dec_cnt_reg;
    logic [5:0]  k_reg;
    logic signed [ACC_W-1:0] acc_reg;
    logic        fir_done_reg;
    pdpo_pkg::pdpo_state_t state_reg;

    wire [5:0] ntaps   = (taps_fld == 6'h00) ? 6'h01 : taps_fld;
    wire [5:0] nsym    = 6'((7'(ntaps) + 7'h01) >> 1);
    wire [5:0] nasym   = (ntaps > 6'h20) ? 6'h20 : ntaps;
    wire [5:0] nterm   = asym ? nasym : nsym;
    wire [5:0] mir_idx = ntaps - 6'h01 - k_reg;
    wire signed [18:0] x_near = 19'(signed'(xline_reg[k_reg]));
    wire signed [18:0] x_far  = 19'(signed'(xline_reg[mir_idx]));
    wire        is_mid = (mir_idx == k_reg);
    wire signed [18:0] term = (asym || is_mid) ? x_near :
                              (odd_sym ? x_near - x_far : x_near + x_far);
    wire signed [ACC_W-1:0] prod = ACC_W'(term * coef_mem[k_reg[4:0]]);
    wire        dec_hit = (dec_cnt_reg == dec_fld);
    wire        last_k  = (k_reg == nterm - 6'h01);
    wire signed [ACC_W-1:0] acc_sum = acc_reg + prod;
    // Add half an LSB then truncate: asymmetric rounding to 16 bits
    wire signed [ACC_W-1:0] acc_rnd = acc_sum + ACC_W'(42'h0_0001_0000);

    // Decimate, then walk the taps one per clock
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int t = 0; t < pdpo_pkg::NTAP; t++) xline_reg[t] <= '0;
            dec_cnt_reg  <= '0;
            k_reg        <= '0;
            acc_reg      <= '0;
            fir_done_reg <= 1'b0;
            freq_reg     <= '0;
            state_reg    <= pdpo_pkg::PDPO_IDLE;
        end else begin
            fir_done_reg <= 1'b0;
            if (fir_stb_reg) begin
                xline_reg[0] <= fir_x_reg;
                for (int t = 1; t < pdpo_pkg::NTAP; t++) xline_reg[t] <= xline_reg[t-1];
                dec_cnt_reg <= dec_hit ? 3'h0 : dec_cnt_reg + 3'h1;
            end
            unique case (state_reg)
                pdpo_pkg::PDPO_IDLE: begin
                    // A decimation slot that lands mid-sum is skipped
                    if (fir_stb_reg && dec_hit) begin
                        k_reg     <= '0;
                        acc_reg   <= '0;
                        state_reg <= pdpo_pkg::PDPO_MAC;
                    end
                end
                pdpo_pkg::PDPO_MAC: begin
                    acc_reg <= acc_sum;
                    k_reg   <= k_reg + 6'h01;
                    if (last_k) begin
                        freq_reg     <= acc_rnd[32:17];
                        fir_done_reg <= 1'b1;
                        state_reg    <= pdpo_pkg::PDPO_IDLE;
                    end
                end
            endcase
        end
    end

    // Symbol-rate words: I/Q on the gate, mag/phase on converter ready
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sym_i_reg <= '0;
            sym_q_reg <= '0;
            mag_reg   <= '0;
            phs_reg   <= '0;
        end else begin
            if (strobe_tap) begin
                sym_i_reg <= conv_i_next[25:10];
                sym_q_reg <= conv_q_next[25:10];
            end
            if (conv_rdy_in) begin
                mag_reg <= conv_mag_in[17:2];
                phs_reg <= conv_phase_in[17:2];
            end
        end
    end

    // Source selection; code three falls back to the first source
    wire [15:0] a_word = (asel == pdpo_pkg::SRC_1) ? mag_reg :
                         (asel == pdpo_pkg::SRC_2) ? freq_reg : sym_i_reg;
    wire [15:0] b_word = (bsel == pdpo_pkg::SRC_1) ? phs_reg :
                         (bsel == pdpo_pkg::SRC_2) ? mag_reg : sym_q_reg;
    wire a_ev = (asel == pdpo_pkg::SRC_1) ? conv_rdy_in :
                (asel == pdpo_pkg::SRC_2) ? fir_done_reg : strobe_tap;
    wire b_ev = (bsel == pdpo_pkg::SRC_1 || bsel == pdpo_pkg::SRC_2) ? conv_rdy_in
                                                                     : strobe_tap;
    logic a_ev_reg, b_ev_reg;

    // Two-entry buffer ahead of the port; events that arrive while it is full are dropped
    logic [32:0] buf_mem [2];
    logic        wr_ptr_reg, rd_ptr_reg;
    logic [1:0]  cnt_reg;
    wire push = (a_ev_reg || b_ev_reg) && (cnt_reg != 2'h2);
    wire pop  = (cnt_reg != 2'h0) && (!out_valid_out || out_ready_in);
    wire [1:0]  cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    wire [32:0] head = buf_mem[rd_ptr_reg];
    wire [7:0]  lo_a = buf_mode ? 8'h00 : head[23:16];
    wire [7:0]  lo_b = buf_mode ? 8'h00 : head[7:0];

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            a_ev_reg   <= 1'b0;
            b_ev_reg   <= 1'b0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= '0;
        end else begin
            a_ev_reg <= a_ev;
            b_ev_reg <= b_ev;
            cnt_reg  <= cnt_next;
            if (push) begin
                buf_mem[wr_ptr_reg] <= {a_ev_reg, a_word, b_word};
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
        end
    end

    // Port registers and data strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            parallel_out_a_out       <= '0;
            parallel_out_b_out       <= '0;
            output_data_strobe_n_out <= 1'b1;
            out_valid_out            <= 1'b0;
            buf_ready_out            <= 1'b1;
            cw_rd_data_out           <= '0;
        end else begin
            buf_ready_out            <= (cnt_next != 2'h2);
            output_data_strobe_n_out <= !(pop && head[32]);
            if (pop) begin
                parallel_out_a_out <= {head[31:24], lo_a};
                parallel_out_b_out <= {head[15:8], lo_b};
                out_valid_out      <= 1'b1;
            end else if (out_ready_in) begin
                out_valid_out <= 1'b0;
            end
            unique case (cw_rd_addr_in)
                pdpo_pkg::CW_DISC:   cw_rd_data_out <= disc_cfg_reg;
                pdpo_pkg::CW_OUTFMT: cw_rd_data_out <= outfmt_cfg_reg;
                pdpo_pkg::CW_ROUTE:  cw_rd_data_out <= route_cfg_reg;
                pdpo_pkg::CW_STATUS: cw_rd_data_out <= {26'h000_0000, cnt_reg,
                                                        dec_cnt_reg, state_reg};
                default:             cw_rd_data_out <= '0;
            endcase
        end
    end

    // Checks
    property p_agc_gate;
        @(posedge clk_in) disable iff (!nrst_in)
        (rs_bypass_in && agc_rdy_in) ##1 rs_bypass_in [*5]
        |=> conv_strobe_out;
    endproperty
    a_agc_gate: assert property (p_agc_gate) else $error("AGC gate late");

    property p_rs_gate;
        @(posedge clk_in) disable iff (!nrst_in)
        (!rs_bypass_in && rs_rdy_in) ##1 !rs_bypass_in [*8]
        |-> ##RS_TAIL conv_strobe_out;
    endproperty
    a_rs_gate: assert property (p_rs_gate) else $error("Resampler gate late");

    property p_route;
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(conv_strobe_out) && $past(direct)
        |-> conv_i_out == $past(fir_i_in);
    endproperty
    a_route: assert property (p_route) else $error("Direct route wrong");

    property p_qzero;
        @(posedge clk_in) disable iff (!nrst_in)
        conv_strobe_out && $past(qzero) && $stable(qzero) |-> conv_q_out == 26'h000_0000;
    endproperty
    a_qzero: assert property (p_qzero) else $error("Q not zeroed");

    property p_strobe_data;
        @(posedge clk_in) disable iff (!nrst_in)
        !output_data_strobe_n_out |-> out_valid_out && $changed(rd_ptr_reg);
    endproperty
    a_strobe_data: assert property (p_strobe_data) else $error("Strobe w/o data");

    property p_disabled;
        @(posedge clk_in) disable iff (!nrst_in)
        !disc_en [*3] |-> !fir_stb_reg;
    endproperty
    a_disabled: assert property (p_disabled) else $error("FIR fed while off");

    property p_mag_in;
        @(posedge clk_in) disable iff (!nrst_in)
        disc_en && fsel == pdpo_pkg::FSEL_MAG && conv_rdy_in
        |=> fir_stb_reg && fir_x_reg == $past(conv_mag_in);
    endproperty
    a_mag_in: assert property (p_mag_in) else $error("Magnitude path wrong");

    property p_diff1;
        @(posedge clk_in) disable iff (!nrst_in)
        ph_stb && dly_fld == 3'h1 && $past(ph_stb) && $stable(mul_sel)
        |=> fir_x_reg == 18'($past(ph_mul) - $past(ph_mul, 2));
    endproperty
    a_diff1: assert property (p_diff1) else $error("Phase difference wrong");
endmodule // pdpo_top

// *** test/pdpo_dsp_model.sv ***
// Far-side processor model latching the parallel port words
`timescale 1ns/1ps
module pdpo_dsp_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // Parallel port side
    input  wire logic [15:0] a_in,
    input  wire logic [15:0] b_in,
    input  wire logic        strobe_n_in,
    input  wire logic        valid_in,
    input  wire logic        stall_in,
    output logic             ready_out,
    output logic [15:0]      last_a_out,
    output logic [15:0]      last_b_out
);
    // No ready while stalled, so the buffer must hold words
    assign ready_out = !stall_in;
    // A taken on the strobe, B on the handshake
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_a_out <= 16'h0000;
            last_b_out <= 16'h0000;
        end else begin
            if (!strobe_n_in) last_a_out <= a_in;
            if (valid_in && ready_out) last_b_out <= b_in;
        end
    end
endmodule // pdpo_dsp_model

// *** test/tb_top.sv ***
// Self-checking bench for the discriminator and parallel output block
`timescale 1ns/1ps
module tb_top;
    // Bench state
    localparam int RS_DLY = 4;
    logic        clk_in, nrst_in, stall, out_ready;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Design inputs
    logic        cw_wr, coef_wr, agc_rdy, rs_rdy, rs_bypass, conv_rdy;
    logic [4:0]  cw_addr, rd_addr, coef_addr;
    logic [31:0] cw_data;
    logic [15:0] coef_data;
    logic [25:0] fir_i, fir_q;
    logic [17:0] rs_i, rs_q, mag, ph;
    // Design outputs and model view
    logic [31:0] rd_data;
    logic [25:0] conv_i, conv_q;
    logic        conv_stb, stb_n, valid, buf_rdy;
    logic [15:0] pa, pb, last_a, last_b;

    pdpo_top #(.RS_DLY(RS_DLY)) i_pdpo_top (
        .clk_in(clk_in), .nrst_in(nrst_in), .cw_wr_in(cw_wr), .cw_addr_in(cw_addr),
        .cw_data_in(cw_data), .cw_rd_addr_in(rd_addr), .cw_rd_data_out(rd_data),
        .coef_wr_in(coef_wr), .coef_addr_in(coef_addr), .coef_data_in(coef_data),
        .fir_i_in(fir_i), .fir_q_in(fir_q), .agc_rdy_in(agc_rdy), .rs_i_in(rs_i),
        .rs_q_in(rs_q), .rs_rdy_in(rs_rdy), .rs_bypass_in(rs_bypass),
        .conv_i_out(conv_i), .conv_q_out(conv_q), .conv_strobe_out(conv_stb),
        .conv_mag_in(mag), .conv_phase_in(ph), .conv_rdy_in(conv_rdy),
        .parallel_out_a_out(pa), .parallel_out_b_out(pb),
        .output_data_strobe_n_out(stb_n), .out_valid_out(valid),
        .out_ready_in(out_ready), .buf_ready_out(buf_rdy));

    pdpo_dsp_model i_pdpo_dsp_model (
        .clk_in(clk_in), .nrst_in(nrst_in), .a_in(pa), .b_in(pb),
        .strobe_n_in(stb_n), .valid_in(valid), .stall_in(stall),
        .ready_out(out_ready), .last_a_out(last_a), .last_b_out(last_b));

    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cw_wr <= 1'b1;
        cw_addr <= a;
        cw_data <= d;
        @(posedge clk_in);
        cw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd_addr <= a;
        repeat (2) @(posedge clk_in);
        #1 chk(rd_data, e);
    endtask

    // Ready pulse; the gate strobe is seen on the n-th edge after it is taken
    task automatic gate(input logic use_agc, input int n);
        @(posedge clk_in);
        if (use_agc) agc_rdy <= 1'b1;
        else rs_rdy <= 1'b1;
        @(posedge clk_in);
        agc_rdy <= 1'b0;
        rs_rdy <= 1'b0;
        repeat (n - 2) @(posedge clk_in);
        #1 chk(32'(conv_stb), 32'h0000_0000);
        @(posedge clk_in);
        #1 chk(32'(conv_stb), 32'h0000_0001);
        repeat (4) @(posedge clk_in);
    endtask

    // Converter result pulse; spacing leaves the one-tap sum time to finish
    task automatic samp(input logic [17:0] m, input logic [17:0] p);
        @(posedge clk_in);
        mag <= m;
        ph <= p;
        conv_rdy <= 1'b1;
        @(posedge clk_in);
        conv_rdy <= 1'b0;
        repeat (12) @(posedge clk_in);
    endtask

    initial begin
        int dv;
        int dd;
        {cw_wr, coef_wr, agc_rdy, rs_rdy, conv_rdy, stall, nrst_in} = '0;
        {cw_addr, rd_addr, coef_addr, cw_data, coef_data} = '0;
        {fir_i, fir_q, rs_i, rs_q, mag, ph} = '0;
        rs_bypass = 1'b1;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1 chk(32'(stb_n), 32'h0000_0001);
        chk(32'(buf_rdy), 32'h0000_0001);
        rd(pdpo_pkg::CW_DISC, 32'h0000_0000);
        rd(pdpo_pkg::CW_OUTFMT, 32'h0000_0000);
        rd(pdpo_pkg::CW_ROUTE, 32'h0000_0000);
        // Field writes one idle cycle apart, then an unmapped word
        cw(pdpo_pkg::CW_DISC, 32'h0001_8A5B);
        cw(pdpo_pkg::CW_OUTFMT, 32'h0250_0000);
        cw(pdpo_pkg::CW_ROUTE, 32'h000C_6000);
        cw(5'h05, 32'hFFFF_FFFF);
        rd(pdpo_pkg::CW_DISC, 32'h0001_8A5B);
        rd(pdpo_pkg::CW_OUTFMT, 32'h0250_0000);
        rd(pdpo_pkg::CW_ROUTE, 32'h000C_6000);
        rd(5'h05, 32'h0000_0000);
        cw(pdpo_pkg::CW_DISC, 32'h0000_0000);
        cw(pdpo_pkg::CW_ROUTE, 32'h0000_2000);
        fir_q <= 26'h1C3_5E97;
        // Direct route, A code 0 and the alias code 3, the latter in buffer mode
        for (int c = 0; c < 4; c += 3) begin
            cw(pdpo_pkg::CW_OUTFMT, (32'(c) << pdpo_pkg::ASEL_LSB)
               | (32'(c[0]) << pdpo_pkg::MODE_BIT));
            fir_i <= 26'h2B4_C3D1 ^ 26'(c);
            gate(1'b1, pdpo_pkg::AGC_DLY);
            chk(32'(conv_i), 32'(fir_i));
            chk(32'(conv_q), 32'(fir_q));
            chk(32'(last_a), 32'({fir_i[25:18], c[0] ? 8'h00 : fir_i[17:10]}));
            chk(32'(last_b), 32'({fir_q[25:18], c[0] ? 8'h00 : fir_q[17:10]}));
        end
        cw(pdpo_pkg::CW_ROUTE, 32'h0000_6000);
        gate(1'b1, pdpo_pkg::AGC_DLY);
        chk(32'(conv_q), 32'h0000_0000);
        chk(32'(last_b), 32'h0000_0000);
        // Legacy route through the resampler
        cw(pdpo_pkg::CW_ROUTE, 32'h0000_0000);
        rs_bypass <= 1'b0;
        rs_i <= 18'h2_A5C3;
        rs_q <= 18'h1_3C5A;
        gate(1'b0, pdpo_pkg::AGC_DLY + RS_DLY);
        chk(32'(conv_i), 32'({rs_i, 8'h00}));
        chk(32'(conv_q), 32'({rs_q, 8'h00}));
        // Magnitude on A, phase on B
        cw(pdpo_pkg::CW_OUTFMT, 32'h0050_0000);
        samp(18'h1_2345, 18'h2_6789);
        chk(32'(last_a), 32'h0000_48D1);
        chk(32'(last_b), 32'h0000_99E2);
        // Frequency on A: one asymmetric tap of half scale
        @(posedge clk_in);
        coef_wr <= 1'b1;
        coef_data <= 16'h4000;
        @(posedge clk_in);
        coef_wr <= 1'b0;
        cw(pdpo_pkg::CW_OUTFMT, 32'h0080_0000);
        for (int d = 0; d < 4; d++) begin
            for (int m = 0; m < 4; m++) begin
                dv = (d * 5 + 1) % 8;
                dd = (dv == 0) ? 8 : dv;
                cw(pdpo_pkg::CW_DISC, 32'(dv) | (32'h1 << pdpo_pkg::ASYM_BIT)
                   | (32'h1 << pdpo_pkg::EN_BIT) | (32'(m) << pdpo_pkg::MUL_LSB));
                // Phase ramp that rolls over mid-run
                for (int k = 0; k < 9; k++) samp(18'h0_0000, 18'(18'h3_FF00 + k * 64));
                chk(32'(last_a), 32'(dd * 8) << m);
            end
        end
        // Delay one with back-to-back phase samples; the second lands mid-sum
        cw(pdpo_pkg::CW_DISC, 32'h0000_4201);
        @(posedge clk_in);
        ph <= 18'h0_0100;
        conv_rdy <= 1'b1;
        @(posedge clk_in);
        ph <= 18'h0_0300;
        @(posedge clk_in);
        conv_rdy <= 1'b0;
        samp(18'h0_0000, 18'h0_0700);
        chk(32'(last_a), 32'h0000_0080);
        cw(pdpo_pkg::CW_ROUTE, 32'h0004_0000);
        samp(18'h0_0400, 18'h0_0000);
        chk(32'(last_a), 32'h0000_0080);
        cw(pdpo_pkg::CW_ROUTE, 32'h0008_0000);
        rs_i <= 18'h0_0800;
        gate(1'b0, pdpo_pkg::AGC_DLY + RS_DLY);
        chk(32'(last_a), 32'h0000_0100);
        cw(pdpo_pkg::CW_DISC, 32'h0000_0000);
        rs_i <= 18'h0_1000;
        gate(1'b0, pdpo_pkg::AGC_DLY + RS_DLY);
        chk(32'(last_a), 32'h0000_0100);
        // Stalled host fills the buffer, then drains it
        cw(pdpo_pkg::CW_OUTFMT, 32'h0000_0000);
        rs_bypass <= 1'b1;
        stall <= 1'b1;
        repeat (4) gate(1'b1, pdpo_pkg::AGC_DLY);
        chk(32'(buf_rdy), 32'h0000_0000);
        @(posedge clk_in);
        stall <= 1'b0;
        repeat (10) @(posedge clk_in);
        #1 chk(32'(valid), 32'h0000_0000);
        chk(32'(buf_rdy), 32'h0000_0001);
        chk(32'(last_b), 32'(rs_q[17:2]));
        summarize();
    end
endmodule // tb_top
